// ---- dam_map.vh ----
// Purpose: constants of the io mapper
// Assumes: apb byte addresses, one word each
// Notes: definitions only
//
// Operation
// - configurable output image starts with fixed prefix
// - five subindex words feed ten item pairs
// - output bits drive supervisor run and reset attributes
// - output fields drive drive-object reference attributes
// - instance 70: fault, forward run, speed
// - instance 71: eight status flags, state, speed
// - instance 72: instance 70 plus torque
// - instance 73: instance 71 plus torque
// - status flags come from supervisor attributes
// - duplicate selectors ignored, missing targets unwritten
// - 9999 gives zero bytes; all 9999 refuses
`ifndef DAM_MAP_VH
`define DAM_MAP_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DAM_OFS_CTRL 12'h000
`define DAM_OFS_FIXSEL 12'h004
`define DAM_OFS_STATUS 12'h008
`define DAM_OFS_MASK 12'h00C
`define DAM_OFS_STATE 12'h010
`define DAM_OFS_SEL 12'h020
`define DAM_OFS_SUB 12'h048
`define DAM_OFS_STEP 12'h004
// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define DAM_UNUSED 16'h270F
`define DAM_RST_CONS 8'h17
`define DAM_RST_PROD 8'h47
`define DAM_INST_CFG 8'h64
`define DAM_INST_20 8'h14
`define DAM_INST_21 8'h15
`define DAM_INST_22 8'h16
`define DAM_INST_23 8'h17
`define DAM_INST_70 8'h46
`define DAM_INST_71 8'h47
`define DAM_INST_72 8'h48
`define DAM_INST_73 8'h49
`define DAM_LEN_SHORT 3'h4
`define DAM_LEN_LONG 3'h6
`define DAM_LEN_NONE 3'h0
`define DAM_TGT_MIN 16'h0001
`define DAM_TGT_MAX 16'h270E
`define DAM_PTR_NONE 4'hF
// ----------------------------------------
// field positions
// ----------------------------------------
`define DAM_LAY_EXT 0
`define DAM_LAY_TRQ 1
`define DAM_CB_FWD 0
`define DAM_CB_REV 1
`define DAM_CB_FRST 2
`define DAM_CB_NCTL 5
`define DAM_CB_NREF 6
`define DAM_ST_RXDONE 0
`define DAM_ST_RXERR 1
`define DAM_ST_REFUSE 2
`define DAM_ST_TXDONE 3
`define DAM_ST_TXERR 4
`define DAM_ST_ITEM 5
`define DAM_ST_W 6
`endif

// ---- dam_item_filter.v ----
// Purpose: qualifies the ten item selectors
// Assumes: 16-bit selectors, item 0 lowest
// Notes: combinational only
`timescale 1ns/1ps
`include "dam_map.vh"
module dam_item_filter (
  // selectors
  input wire [159:0] sel_flat,
  // qualified masks
  output wire [9:0] used,
  output wire [9:0] exists,
  output reg [4:0] count
);
  // ----------------------------------------
  // per item qualification
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1)
    begin : g_item
      wire [15:0] me = sel_flat[16*gi +: 16];
      reg dup;
      integer j;
      // lower numbered selector wins a duplicate
      always @*
      begin
        dup = 1'b0;
        for (j = 0; j < gi; j = j + 1)
        begin
          if (sel_flat[16*j +: 16] == me)
            dup = 1'b1;
        end
      end
      assign used[gi] = (me != `DAM_UNUSED) && !dup;
      // bad target uses bytes, never written
      assign exists[gi] = used[gi] && (me >= `DAM_TGT_MIN) &&
                          (me <= `DAM_TGT_MAX);
    end
  endgenerate
  // ----------------------------------------
  // number of items that occupy image bytes
  // ----------------------------------------
  integer k;
  always @*
  begin
    count = 5'h00;
    for (k = 0; k < 10; k = k + 1)
    begin
      count = count + {4'h0, used[k]};
    end
  end
endmodule

// ---- dam_in_packer.v ----
// Purpose: bytes of produced instances 70 to 73
// Assumes: flags sampled live, caller registers the byte
// Notes: unknown instance: length zero
`timescale 1ns/1ps
`include "dam_map.vh"
module dam_in_packer (
  // selection
  input wire [7:0] inst,
  input wire [2:0] idx,
  // drive status sources
  input wire [7:0] flags,
  input wire [7:0] drive_state,
  input wire [15:0] speed_actual,
  input wire [15:0] torque_actual,
  // result
  output reg [7:0] byte_out,
  output reg [2:0] len,
  output reg inst_ok
);
  reg ext;
  reg [7:0] b0;
  // ----------------------------------------
  // layout choice and byte mux
  // ----------------------------------------
  always @*
  begin
    ext = 1'b0;
    len = `DAM_LEN_NONE;
    inst_ok = 1'b1;
    case (inst)
      `DAM_INST_70: len = `DAM_LEN_SHORT;
      `DAM_INST_71:
      begin
        len = `DAM_LEN_SHORT;
        ext = 1'b1;
      end
      `DAM_INST_72: len = `DAM_LEN_LONG;
      `DAM_INST_73:
      begin
        len = `DAM_LEN_LONG;
        ext = 1'b1;
      end
      default: inst_ok = 1'b0;
    endcase
    // basic layouts keep fault and forward only
    b0 = ext ? flags : (flags & 8'h05);
    case (idx)
      3'h0: byte_out = b0;
      3'h1: byte_out = ext ? drive_state : 8'h00;
      3'h2: byte_out = speed_actual[7:0];
      3'h3: byte_out = speed_actual[15:8];
      3'h4: byte_out = torque_actual[7:0];
      3'h5: byte_out = torque_actual[15:8];
      default: byte_out = 8'h00;
    endcase
  end
endmodule

// ---- dam_io_mapper.v ----
// Purpose: drive assembly images
// Assumes: streams synchronous to pclk
// Notes: all outputs registered, one level interrupt
`timescale 1ns/1ps
`include "dam_map.vh"
module dam_io_mapper (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_ff,
  output reg pready_ff,
  output reg pslverr_ff,
  output reg irq_ff,
  // consumed image stream
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_last,
  // supervisor attributes out
  output reg run_forward_attr,
  output reg run_reverse_attr,
  output reg fault_reset_attr,
  output reg network_control_select,
  // drive object attributes out
  output reg network_reference_select,
  output reg [15:0] speed_reference_attr,
  output reg [15:0] torque_reference_attr,
  // configurable item writes
  output reg item_wr_ff,
  output reg [15:0] item_target_ff,
  output reg [7:0] item_subindex_ff,
  output reg [15:0] item_data_ff,
  // drive status in
  input wire faulted,
  input wire warning,
  input wire forward_running_flag,
  input wire reverse_running_flag,
  input wire drive_ready,
  input wire control_from_network_flag,
  input wire reference_from_network,
  input wire at_reference,
  input wire [7:0] drive_state,
  input wire [15:0] speed_actual,
  input wire [15:0] torque_actual,
  // produced image stream
  input wire tx_start,
  input wire tx_ready,
  output reg tx_valid_ff,
  output reg [7:0] tx_data_ff,
  output reg tx_last_ff
);
  // ----------------------------------------
  // register storage
  // ----------------------------------------
  reg [7:0] cons_ff; // consumed instance in use
  reg [7:0] prod_ff; // produced instance in use
  reg [15:0] out_fixed_format_select;
  reg [15:0] out_item_target_selectors [0:9];
  reg [15:0] out_item_subindex_pairs [0:4];
  reg [`DAM_ST_W-1:0] status_ff; // sticky events
  reg [`DAM_ST_W-1:0] mask_ff; // interrupt enables
  reg [`DAM_ST_W-1:0] ev; // events of this cycle
  reg [`DAM_ST_W-1:0] rd_clr_ff; // bits shown by a status read
  reg [31:0] rd_data;
  reg rd_hit;
  integer k;
  integer m; // own loop index, k belongs to the read decode

  wire setup = psel & ~penable;
  wire acc = psel & penable & pready_ff; // the one effective edge
  wire wr_acc = acc & pwrite;
  wire rd_acc = acc & ~pwrite;

  // ----------------------------------------
  // item qualification
  // ----------------------------------------
  wire [159:0] sel_flat;
  wire [9:0] used;
  wire [9:0] exists;
  wire [4:0] count;
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1)
    begin : g_flat
      assign sel_flat[16*gi +: 16] = out_item_target_selectors[gi];
    end
  endgenerate

  dam_item_filter u_filter (
    .sel_flat(sel_flat),
    .used(used),
    .exists(exists),
    .count(count)
  );

  // refuse when the fixed prefix select and every item selector are unused
  wire conn_ok = (out_fixed_format_select != `DAM_UNUSED) ||
                 (|used);

  // ----------------------------------------
  // read decode, sampled in the setup cycle
  // ----------------------------------------
  always @*
  begin
    rd_data = 32'h00000000;
    rd_hit = 1'b1;
    case (paddr)
      `DAM_OFS_CTRL: rd_data = {16'h0000, prod_ff, cons_ff};
      `DAM_OFS_FIXSEL: rd_data = {16'h0000, out_fixed_format_select};
      `DAM_OFS_STATUS: rd_data = {26'h0, status_ff};
      `DAM_OFS_MASK: rd_data = {26'h0, mask_ff};
      `DAM_OFS_STATE: rd_data = {6'h00, used, 3'h0, count,
                                 6'h00, tx_valid_ff, conn_ok};
      default:
      begin
        rd_hit = 1'b0;
        for (k = 0; k < 10; k = k + 1)
        begin
          if (paddr == `DAM_OFS_SEL + `DAM_OFS_STEP * k)
          begin
            rd_hit = 1'b1;
            rd_data = {16'h0000, out_item_target_selectors[k]};
          end
        end
        for (k = 0; k < 5; k = k + 1)
        begin
          if (paddr == `DAM_OFS_SUB + `DAM_OFS_STEP * k)
          begin
            rd_hit = 1'b1;
            rd_data = {16'h0000, out_item_subindex_pairs[k]};
          end
        end
      end
    endcase
  end

  // ----------------------------------------
  // apb handshake: ready one cycle after setup
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      rd_clr_ff <= {`DAM_ST_W{1'b0}};
    end
    else
    begin
      pready_ff <= setup;
      if (setup)
      begin
        pslverr_ff <= ~rd_hit; // unmapped: error, data zero
        prdata_ff <= pwrite ? 32'h00000000 : rd_data;
        // clear only what this read showed
        rd_clr_ff <= (!pwrite && paddr == `DAM_OFS_STATUS) ?
                     status_ff : {`DAM_ST_W{1'b0}};
      end
      else if (acc)
      begin
        pslverr_ff <= 1'b0;
        rd_clr_ff <= {`DAM_ST_W{1'b0}};
      end
    end
  end

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cons_ff <= `DAM_RST_CONS;
      prod_ff <= `DAM_RST_PROD;
      out_fixed_format_select <= `DAM_UNUSED;
      mask_ff <= {`DAM_ST_W{1'b0}};
    end
    else if (wr_acc)
    begin
      case (paddr)
        `DAM_OFS_CTRL:
        begin
          cons_ff <= pwdata[7:0];
          prod_ff <= pwdata[15:8];
        end
        `DAM_OFS_FIXSEL: out_fixed_format_select <= pwdata[15:0];
        `DAM_OFS_MASK: mask_ff <= pwdata[`DAM_ST_W-1:0];
        default: mask_ff <= mask_ff;
      endcase
    end
  end

  // selector and subindex words
  generate
    for (gi = 0; gi < 10; gi = gi + 1)
    begin : g_sel
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          out_item_target_selectors[gi] <= `DAM_UNUSED;
        else if (wr_acc && paddr == `DAM_OFS_SEL + `DAM_OFS_STEP * gi)
          out_item_target_selectors[gi] <= pwdata[15:0];
      end
    end
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_sub
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          out_item_subindex_pairs[gi] <= 16'h0000;
        else if (wr_acc && paddr == `DAM_OFS_SUB + `DAM_OFS_STEP * gi)
          out_item_subindex_pairs[gi] <= pwdata[15:0];
      end
    end
  endgenerate

  // ----------------------------------------
  // consumed image layout
  // ----------------------------------------
  wire is_cfg = (cons_ff == `DAM_INST_CFG);
  // cfg image takes the chosen prefix
  wire [7:0] lay = is_cfg ? out_fixed_format_select[7:0] : cons_ff;
  wire lay_hi_ok = !is_cfg || (out_fixed_format_select[15:8] == 8'h00);
  reg [2:0] pre_len;
  always @*
  begin
    pre_len = `DAM_LEN_NONE;
    if (lay_hi_ok)
    begin
      case (lay)
        `DAM_INST_20, `DAM_INST_21: pre_len = `DAM_LEN_SHORT;
        `DAM_INST_22, `DAM_INST_23: pre_len = `DAM_LEN_LONG;
        default: pre_len = `DAM_LEN_NONE;
      endcase
    end
  end
  wire ext = lay[`DAM_LAY_EXT];
  wire trq = lay[`DAM_LAY_TRQ];
  wire [5:0] exp_len = is_cfg ? ({3'h0, pre_len} + {count, 1'b0}) :
                       {3'h0, pre_len};

  reg [5:0] ridx_ff; // byte index within the frame
  reg [3:0] ptr_ff; // item owning the next byte pair
  reg [7:0] lo_ff; // low byte of the item pair
  reg [3:0] first_ptr;
  reg [3:0] next_ptr;
  wire [5:0] rel = ridx_ff - {3'h0, pre_len};
  wire refused = is_cfg & ~conn_ok;

  // first used item and the one after ptr_ff
  always @*
  begin
    first_ptr = `DAM_PTR_NONE;
    next_ptr = `DAM_PTR_NONE;
    for (m = 9; m >= 0; m = m - 1)
    begin
      if (used[m])
      begin
        first_ptr = m[3:0];
        if (m[3:0] > ptr_ff)
          next_ptr = m[3:0];
      end
    end
  end

  // subindex of the current item: even item low, odd item high
  wire [15:0] sub_word = out_item_subindex_pairs[ptr_ff[3:1]];
  wire [7:0] cur_sub = ptr_ff[0] ? sub_word[15:8] :
                       sub_word[7:0];

  // ----------------------------------------
  // consumed frame parser
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ridx_ff <= 6'h00;
      ptr_ff <= `DAM_PTR_NONE;
      lo_ff <= 8'h00;
      run_forward_attr <= 1'b0;
      run_reverse_attr <= 1'b0;
      fault_reset_attr <= 1'b0;
      network_control_select <= 1'b0;
      network_reference_select <= 1'b0;
      speed_reference_attr <= 16'h0000;
      torque_reference_attr <= 16'h0000;
      item_wr_ff <= 1'b0;
      item_target_ff <= 16'h0000;
      item_subindex_ff <= 8'h00;
      item_data_ff <= 16'h0000;
    end
    else
    begin
      item_wr_ff <= 1'b0;
      if (rx_valid)
      begin
        // reload pointer at frame end
        ridx_ff <= rx_last ? 6'h00 :
                   (ridx_ff == 6'h3F ? ridx_ff : ridx_ff + 6'h01);
        if (rx_last)
          ptr_ff <= first_ptr;
        if (refused)
          ptr_ff <= first_ptr;
        else if (ridx_ff < {3'h0, pre_len})
        begin
          case (ridx_ff[2:0])
            3'h0:
            begin
              run_forward_attr <= rx_data[`DAM_CB_FWD];
              fault_reset_attr <= rx_data[`DAM_CB_FRST];
              if (ext)
              begin
                run_reverse_attr <= rx_data[`DAM_CB_REV];
                network_control_select <= rx_data[`DAM_CB_NCTL];
                network_reference_select <= rx_data[`DAM_CB_NREF];
              end
            end
            3'h2: speed_reference_attr[7:0] <= rx_data;
            3'h3: speed_reference_attr[15:8] <= rx_data;
            3'h4:
            begin
              if (trq)
                torque_reference_attr[7:0] <= rx_data;
            end
            3'h5:
            begin
              if (trq)
                torque_reference_attr[15:8] <= rx_data;
            end
            default: lo_ff <= lo_ff;
          endcase
        end
        else if (is_cfg && ptr_ff != `DAM_PTR_NONE)
        begin
          // items follow the prefix, two bytes each
          if (!rel[0])
            lo_ff <= rx_data;
          else
          begin
            item_wr_ff <= exists[ptr_ff];
            item_target_ff <= out_item_target_selectors[ptr_ff];
            item_subindex_ff <= cur_sub;
            item_data_ff <= {rx_data, lo_ff};
            if (!rx_last)
              ptr_ff <= next_ptr;
          end
        end
      end
      else if (ridx_ff == 6'h00)
        ptr_ff <= first_ptr; // follow selector edits between frames
    end
  end

  // ----------------------------------------
  // produced image sender
  // ----------------------------------------
  localparam TX_IDLE = 2'b01;
  localparam TX_SEND = 2'b10;
  reg [1:0] tx_st_ff;
  reg [2:0] tx_idx_ff;
  wire [7:0] pk_byte;
  wire [2:0] pk_len;
  wire pk_ok;
  wire [2:0] pk_idx = (tx_st_ff == TX_IDLE) ? 3'h0 : tx_idx_ff + 3'h1;
  // supervisor status flags, msb first
  wire [7:0] flags = {at_reference, reference_from_network,
                      control_from_network_flag, drive_ready,
                      reverse_running_flag, forward_running_flag,
                      warning, faulted};

  dam_in_packer u_packer (
    .inst(prod_ff),
    .idx(pk_idx),
    .flags(flags),
    .drive_state(drive_state),
    .speed_actual(speed_actual),
    .torque_actual(torque_actual),
    .byte_out(pk_byte),
    .len(pk_len),
    .inst_ok(pk_ok)
  );

  // busy start ignored; bad instance flags error
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_st_ff <= TX_IDLE;
      tx_idx_ff <= 3'h0;
      tx_valid_ff <= 1'b0;
      tx_data_ff <= 8'h00;
      tx_last_ff <= 1'b0;
    end
    else
    begin
      case (tx_st_ff)
        TX_IDLE:
        begin
          if (tx_start && pk_ok)
          begin
            tx_st_ff <= TX_SEND;
            tx_idx_ff <= 3'h0;
            tx_valid_ff <= 1'b1;
            tx_data_ff <= pk_byte;
            tx_last_ff <= 1'b0;
          end
        end
        TX_SEND:
        begin
          if (tx_ready)
          begin
            if (tx_last_ff)
            begin
              tx_st_ff <= TX_IDLE;
              tx_valid_ff <= 1'b0;
              tx_last_ff <= 1'b0;
            end
            else
            begin
              tx_idx_ff <= pk_idx;
              tx_data_ff <= pk_byte;
              tx_last_ff <= (pk_idx == pk_len - 3'h1);
            end
          end
        end
        default:
        begin
          tx_st_ff <= TX_IDLE;
          tx_valid_ff <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // events, sticky status and interrupt
  // ----------------------------------------
  wire len_ok = (ridx_ff + 6'h01 == exp_len) && (pre_len != `DAM_LEN_NONE
                || is_cfg);
  always @*
  begin
    ev = {`DAM_ST_W{1'b0}};
    ev[`DAM_ST_RXDONE] = rx_valid & rx_last & ~refused & len_ok;
    ev[`DAM_ST_RXERR] = rx_valid & rx_last & ~refused & ~len_ok;
    ev[`DAM_ST_REFUSE] = rx_valid & rx_last & refused;
    ev[`DAM_ST_TXDONE] = (tx_st_ff == TX_SEND) & tx_ready & tx_last_ff;
    ev[`DAM_ST_TXERR] = (tx_st_ff == TX_IDLE) & tx_start & ~pk_ok;
    ev[`DAM_ST_ITEM] = item_wr_ff;
  end

  // a new event beats the read clear
  wire [`DAM_ST_W-1:0] nxt_status =
    (status_ff & ~(rd_acc ? rd_clr_ff : {`DAM_ST_W{1'b0}})) | ev;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_ff <= {`DAM_ST_W{1'b0}};
      irq_ff <= 1'b0;
    end
    else
    begin
      status_ff <= nxt_status;
      irq_ff <= |(nxt_status & mask_ff);
    end
  end
endmodule

// ---- dam_io_mapper_asserts.sv ----
// Purpose: port checks on the produced image stream
// Assumes: status steady within a frame
// Notes: shadows the produced instance
`timescale 1ns/1ps
module dam_io_mapper_asserts (
  // clock, reset, apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready_ff,
  // drive status
  input wire faulted,
  input wire warning,
  input wire forward_running_flag,
  input wire reverse_running_flag,
  input wire drive_ready,
  input wire control_from_network_flag,
  input wire reference_from_network,
  input wire at_reference,
  input wire [7:0] drive_state,
  input wire [15:0] speed_actual,
  input wire [15:0] torque_actual,
  // produced stream
  input wire tx_ready,
  input wire tx_valid_ff,
  input wire [7:0] tx_data_ff,
  input wire tx_last_ff
);
  // ----------------
  // helpers
  // ----------------
  reg [7:0] prod_ff; // shadow of produced instance
  reg [2:0] idx_ff; // byte number within the frame
  wire hs = tx_valid_ff && tx_ready; // byte taken by the sink
  wire [7:0] ext = {at_reference, reference_from_network,
    control_from_network_flag, drive_ready, reverse_running_flag,
    forward_running_flag, warning, faulted};
  // shadow follows writes at the access edge
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      prod_ff <= 8'h47;
      idx_ff <= 3'h0;
    end
    else
    begin
      if (psel && penable && pready_ff && pwrite && paddr == 12'h000)
        prod_ff <= pwdata[15:8];
      if (hs)
        idx_ff <= tx_last_ff ? 3'h0 : idx_ff + 3'h1;
    end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------
  // assertions
  // ----------------
  b0_basic_a:
    assert property (tx_valid_ff && idx_ff == 3'h0 && !prod_ff[0] |->
      tx_data_ff == {5'h00, forward_running_flag, 1'b0, faulted})
    else $error("basic status byte wrong");
  b0_ext_a:
    assert property (tx_valid_ff && idx_ff == 3'h0 && prod_ff[0] |->
      tx_data_ff == ext) else $error("extended status byte wrong");
  b1_fmt_a:
    assert property (tx_valid_ff && idx_ff == 3'h1 |->
      tx_data_ff == (prod_ff[0] ? drive_state : 8'h00))
    else $error("second byte wrong");
  spd_lo_a:
    assert property (tx_valid_ff && idx_ff == 3'h2 |->
      tx_data_ff == speed_actual[7:0]) else $error("speed low wrong");
  spd_hi_a:
    assert property (tx_valid_ff && idx_ff == 3'h3 |->
      tx_data_ff == speed_actual[15:8]) else $error("speed high wrong");
  trq_bytes_a:
    assert property (tx_valid_ff && idx_ff[2] |-> tx_data_ff ==
      (idx_ff[0] ? torque_actual[15:8] : torque_actual[7:0]))
    else $error("torque byte wrong");
  frame_len_a:
    assert property (tx_valid_ff && tx_last_ff |->
      idx_ff == (prod_ff[3] ? 3'h5 : 3'h3)) else $error("frame length wrong");
  tx_hold_a:
    assert property (tx_valid_ff && !tx_ready |=> tx_valid_ff &&
      $stable(tx_data_ff) && $stable(tx_last_ff)) else $error("byte not held");
  cover property (hs && tx_last_ff && prod_ff[3]);
  cover property (hs && tx_last_ff && !prod_ff[3]);
  cover property (tx_valid_ff && !tx_ready);
endmodule
bind dam_io_mapper dam_io_mapper_asserts i_chk (.*);

// ---- dam_scanner_model.sv ----
// Purpose: network scanner side of both image streams
// Assumes: one pclk domain, tasks entered after a clock edge
// Notes: sink stalls one cycle in four
`timescale 1ns/1ps
module dam_scanner_model (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // consumed image stream
  output logic rx_valid = 1'b0,
  output logic [7:0] rx_data = 8'h00,
  output logic rx_last = 1'b0,
  // produced image stream
  output logic tx_start = 1'b0,
  output logic tx_ready = 1'b0
);
  // random sink stalls
  always @(posedge pclk)
    tx_ready <= presetn && ($urandom_range(3) != 0);
  // one frame, a byte a cycle, last byte flagged
  task send(input logic [7:0] q [$]);
    foreach (q[i])
    begin
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_data <= q[i];
      rx_last <= (i == q.size() - 1);
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~q[q.size() - 1]; // idle lines differ
  endtask
  // one-cycle request for a produced frame
  task start_tx();
    @(posedge pclk);
    tx_start <= 1'b1;
    @(posedge pclk);
    tx_start <= 1'b0;
  endtask
endmodule

// ---- dam_io_mapper_tb.sv ----
// Purpose: self-checking bench for dam_io_mapper
// Assumes: scanner model drives both image streams
// Notes: queued notes, one monitor
`timescale 1ns/1ps
module dam_io_mapper_tb;
  // ----------------
  // signals
  // ----------------
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, e, pready_ff, pslverr_ff, irq_ff, rx_valid, rx_last;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, r, prdata_ff;
  logic [7:0] st = 8'h00, drive_state = 8'h00, ins, b0, ds, rx_data;
  logic [15:0] speed_actual = 16'h0, torque_actual = 16'h0, sp, tq;
  wire faulted = st[0], warning = st[1], forward_running_flag = st[2];
  wire reverse_running_flag = st[3], drive_ready = st[4];
  wire control_from_network_flag = st[5], reference_from_network = st[6];
  wire at_reference = st[7];
  logic [15:0] speed_reference_attr, torque_reference_attr, item_data_ff;
  logic [15:0] item_target_ff;
  logic [7:0] tx_data_ff, item_subindex_ff, exp_tx [$], fr [$];
  logic run_forward_attr, run_reverse_attr, fault_reset_attr, item_wr_ff;
  logic network_control_select, network_reference_select, tx_start;
  logic tx_ready, tx_valid_ff, tx_last_ff;
  logic [39:0] exp_item [$];
  // reset table, config and refusal writes
  logic [11:0] ra [5] = '{12'h000, 12'h004, 12'h020, 12'h048, 12'h100};
  logic [31:0] rv [5] = '{32'h4717, 32'h270F, 32'h270F, 32'h0, 32'h0};
  logic [11:0] ca [12] = '{12'h00C, 12'h004, 12'h020, 12'h024, 12'h02C,
    12'h048, 12'h04C, 12'h000, 12'h004, 12'h020, 12'h024, 12'h02C};
  logic [31:0] cd [12] = '{32'h21, 32'h14, 32'h5, 32'h5, 32'h7, 32'hBBAA,
    32'hDD00, 32'h4764, 32'h270F, 32'h270F, 32'h270F, 32'h270F};
  int errors = 0, n_checks = 0;
  dam_io_mapper i_dut (.*);
  dam_scanner_model i_scn (.*);
  always #5 pclk = ~pclk;
  // ----------------
  // tasks
  // ----------------
  task chk(input string nm, input logic [39:0] x, input logic [39:0] g);
    n_checks++;
    if (g !== x)
    begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", nm, x, g);
    end
  endtask
  // apb transfer; data taken at ready edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready_ff !== 1'b1);
    r = prdata_ff;
    e = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // monitor: oldest note per result
  always @(posedge pclk)
  begin
    if (tx_valid_ff === 1'b1 && tx_ready === 1'b1)
      chk("tx byte", exp_tx.size() ? exp_tx.pop_front() : 'x, tx_data_ff);
    if (item_wr_ff === 1'b1)
      chk("item", exp_item.size() ? exp_item.pop_front() : 'x, {item_target_ff,
        item_subindex_ff, item_data_ff});
  end
  initial
  begin
    #100000;
    errors++;
    results();
  end
  // ----------------
  // tests
  // ----------------
  initial
  begin
    void'($urandom(6));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[i])
    begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset value", {ra[i] == 12'h100, rv[i]}, {e, r});
    end
    for (int i = 0; i < 4; i++)
    begin
      ins = 8'h46 + 8'(i);
      apb(1'b1, 12'h000, {16'h0, ins, 8'h17});
      {b0, ds, sp, tq} = 48'({$urandom, $urandom});
      st <= b0;
      drive_state <= ds;
      speed_actual <= sp;
      torque_actual <= tq;
      fr = '{ins[0] ? b0 : {5'h00, b0[2], 1'b0, b0[0]}, ins[0] ? ds : 8'h00,
        sp[7:0], sp[15:8], tq[7:0], tq[15:8]};
      exp_tx = ins[3] ? fr : fr[0:3];
      i_scn.start_tx();
      while (exp_tx.size() != 0) @(posedge pclk);
    end
    $display("produced images done");
    repeat (2)
    begin
      b0 = 8'($urandom) & 8'h67;
      sp = 16'($urandom);
      tq = 16'($urandom);
      i_scn.send('{b0, 8'h00, sp[7:0], sp[15:8], tq[7:0], tq[15:8]});
      repeat (2) @(posedge pclk);
      chk("ctrl bits", {b0[6:5], b0[2:0]}, {network_reference_select,
        network_control_select, fault_reset_attr, run_reverse_attr,
        run_forward_attr});
      chk("refs", {sp, tq}, {speed_reference_attr, torque_reference_attr});
    end
    $display("consumed images done");
    for (int i = 0; i < 8; i++)
      apb(1'b1, ca[i], cd[i]);
    apb(1'b0, 12'h008, 32'h0);
    exp_item = '{{16'h0005, 8'hAA, 16'h1234}, {16'h0007, 8'hDD, 16'h5678}};
    i_scn.send('{8'h05, 8'h00, 8'h11, 8'h22, 8'h34, 8'h12, 8'h78, 8'h56});
    repeat (3) @(posedge pclk);
    chk("prefix", {run_forward_attr, fault_reset_attr, speed_reference_attr},
      {2'b11, 16'h2211});
    chk("irq set", 1'b1, irq_ff);
    apb(1'b0, 12'h008, 32'h0);
    chk("status", 32'h21, r);
    repeat (2) @(posedge pclk);
    chk("irq clear", 1'b0, irq_ff);
    $display("configurable image done");
    for (int i = 8; i < 12; i++)
      apb(1'b1, ca[i], cd[i]);
    i_scn.send('{8'h02, 8'h00});
    repeat (3) @(posedge pclk);
    chk("masked irq", 1'b0, irq_ff);
    chk("refused hold", 17'h12211, {run_forward_attr, speed_reference_attr});
    apb(1'b0, 12'h008, 32'h0);
    chk("refused", 1'b1, r[2]);
    $display("refusal done");
    results();
  end
endmodule
